// >>> hw/dfc_defs.vh
// Constants for the distributor function-control register bank.
// Assumes an APB slave with 32-bit data and one word per register.
//
// Function
// RL1: Width bit zero means sixteen-bit identifier
// RL2: Width field returns build-time width parameter
// RL3: Both fields zero without direct injection
// RL4: Direct injection support bit gates capability
// RL5: Function control acts on local chip only
// RL6: Serialize remote shared-irq writes before response
// RL7: Only edge interrupts; else store, respond
// RL8: Limit zero means token maximum, else cap
// RL9: Limit above token maximum acts as zero
// RL10: Error access field applied to faulty SPIs
// RL11: Secure-only fields ignore non-secure accesses
// RL12: Scrub bit shows running; write starts/aborts
// RL13: Scrub walks every local RAM
// RL14: Scrub bit clears itself when finished
// RL15: Read-only and reserved writes ignored, read zero
`ifndef DFC_DEFS_VH
`define DFC_DEFS_VH

// Register byte offsets
`define DFC_OFS_WIDTH_INFO 12'h00C
`define DFC_OFS_FUNC_CTL 12'h020
`define DFC_ADDR_W 12

// Capability register fields
`define DFC_IND_BIT 7
`define DFC_FIELD_HI 4
`define DFC_FIELD_LO 0
`define DFC_WIDTH_16 5'h0F

// Function control fields
`define DFC_SER_BIT 26
`define DFC_LIM_HI 23
`define DFC_LIM_LO 20
`define DFC_ACC_HI 17
`define DFC_ACC_LO 16
`define DFC_SCRUB_BIT 0

// Reset values
`define DFC_SER_RST 1'h0
`define DFC_LIM_RST 4'h0
`define DFC_ACC_RST 2'h0
`define DFC_LIM_ZERO 4'h0

// APB protection bit carrying non-secure
`define DFC_PROT_NS 1

`endif

// >>> hw/dfc_scrub_walker.v
// Scrub sequencer: walks every word of every local RAM once.
// Assumes each RAM answers one scrub request per acknowledge pulse.
`include "dfc_defs.vh"

module dfc_scrub_walker #(
  parameter NUM_RAMS = 4,
  parameter RAM_SEL_W = 2,
  parameter ADDR_W = 10,
  parameter [ADDR_W-1:0] LAST_ADDR = 10'h3FF
) (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire abort,
  input wire scrub_ack,
  output reg scrub_req,
  output reg [RAM_SEL_W-1:0] scrub_ram,
  output reg [ADDR_W-1:0] scrub_addr,
  output reg done
);

  // Index of the last RAM, cut to the select width on purpose
  localparam integer LAST_RAM_I = NUM_RAMS - 1;
  localparam [RAM_SEL_W-1:0] LAST_RAM = LAST_RAM_I[RAM_SEL_W-1:0];

  // Walk RAM by RAM, word by word; abort stops without done
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scrub_req <= 1'b0;
      scrub_ram <= {RAM_SEL_W{1'b0}};
      scrub_addr <= {ADDR_W{1'b0}};
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        // Drop the walk at once
        scrub_req <= 1'b0;
      end else if (start && !scrub_req) begin
        // Begin at the first word of the first RAM
        scrub_req <= 1'b1;
        scrub_ram <= {RAM_SEL_W{1'b0}};
        scrub_addr <= {ADDR_W{1'b0}};
      end else if (scrub_req && scrub_ack) begin
        if (scrub_addr == LAST_ADDR) begin
          scrub_addr <= {ADDR_W{1'b0}};
          if (scrub_ram == LAST_RAM) begin
            // Every RAM covered
            scrub_req <= 1'b0; // RL13
            done <= 1'b1;
          end else begin
            scrub_ram <= scrub_ram + 1'b1; // RL13
          end
        end else begin
          scrub_addr <= scrub_addr + 1'b1;
        end
      end
    end
  end

endmodule

// >>> hw/dfc_top.v
// Capability and function-control registers of the local distributor,
// with the scrub sequencer, shared-irq write serialization and the
// cross-chip LPI limit decode.
// Assumes an APB master on pclk and same-clock request logic.
// The remote forward path and the RAMs run on the same clock, so no
// input here is synchronised; a pin from another domain would need two
// flops in front of it.
//
// Added by the designer: the APB register port and the register addresses.
`include "dfc_defs.vh"

module dfc_top #(
  parameter DIRECT_INJECTION = 1,
  parameter [4:0] VPE_WIDTH = 5'h0F,
  parameter TOKEN_W = 4,
  parameter [TOKEN_W-1:0] TOKEN_MAX = 4'h8,
  parameter NUM_RAMS = 4,
  parameter RAM_SEL_W = 2,
  parameter RAM_ADDR_W = 10,
  parameter [RAM_ADDR_W-1:0] RAM_LAST_ADDR = 10'h3FF
) (
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`DFC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [2:0] pprot,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Remote set/clear shared-irq write from the distributor
  input wire spi_req_valid,
  input wire spi_req_edge,
  input wire spi_req_remote,
  output reg spi_req_ready,
  output reg spi_resp_valid,
  // Forwarding toward the remote chip
  output reg spi_fwd_valid,
  input wire spi_fwd_ack,
  // Effective settings for the rest of the distributor
  output reg [TOKEN_W-1:0] cc_lpi_limit,
  output reg [1:0] err_spi_access,
  // RAM scrub port
  output reg scrub_req,
  output reg [RAM_SEL_W-1:0] scrub_ram,
  output reg [RAM_ADDR_W-1:0] scrub_addr,
  input wire scrub_ack
);

  // Forwarding states
  // Idle takes requests; hold withholds the response; post only forwards
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_HOLD = 2'b01;
  localparam [1:0] ST_POST = 2'b10;

  // Capability word: both fields vanish without direct injection
  // The indicator is low only for a sixteen-bit identifier, which the
  // width field encodes as fifteen; wider field values are reserved.
  function [31:0] dfc_width_word;
    input direct_injection_support;
    input [4:0] width;
    begin
      dfc_width_word = 32'h00000000; // RL15
      if (direct_injection_support) begin // RL4 RL3
        dfc_width_word[`DFC_FIELD_HI:`DFC_FIELD_LO] = width; // RL2
        dfc_width_word[`DFC_IND_BIT] = (width != `DFC_WIDTH_16); // RL1
      end
    end
  endfunction

  // Limit decode: zero or above the maximum selects the maximum
  // A cap above the token maximum is treated like zero, so the rest of
  // the distributor never sees a limit that it cannot honour.
  function [TOKEN_W-1:0] dfc_limit;
    input [3:0] field;
    input [TOKEN_W-1:0] tmax;
    begin
      if (field == `DFC_LIM_ZERO) begin
        dfc_limit = tmax; // RL8
      end else if ({{TOKEN_W{1'b0}}, field} > {4'h0, tmax}) begin
        dfc_limit = tmax; // RL9
      end else begin
        dfc_limit = field[TOKEN_W-1:0]; // RL8
      end
    end
  endfunction

  // Control state of the function control register
  // Only the scrub bit is open to non-secure software
  reg ser_en; // Serialize remote shared-irq writes
  reg [3:0] lim_field; // Cross-chip LPI limit as written
  reg [1:0] acc_field; // Access control for faulty SPIs
  reg scrub_on; // Scrub running
  // Forwarding state
  reg [1:0] fwd_state;
  // Scrub walker handshake
  // Start and abort are one-cycle pulses toward the walker
  reg walk_start;
  reg walk_abort;
  wire walk_req;
  wire [RAM_SEL_W-1:0] walk_ram;
  wire [RAM_ADDR_W-1:0] walk_addr;
  wire walk_done;

  // Bus decode
  // A write takes effect only at the edge where pready is sampled high,
  // so the setup and first access cycles never change a register.
  // The security state comes from the protection bits of each transfer.
  wire bus_access = psel && penable;
  wire bus_commit = bus_access && pready;
  wire is_ns = pprot[`DFC_PROT_NS];
  wire hit_info = (paddr == `DFC_OFS_WIDTH_INFO);
  wire hit_ctl = (paddr == `DFC_OFS_FUNC_CTL);
  wire hit_any = hit_info || hit_ctl;
  wire ctl_write = bus_commit && pwrite && hit_ctl;
  wire sec_write = ctl_write && !is_ns;
  wire wr_scrub = pwdata[`DFC_SCRUB_BIT];

  // Read word of the function control register
  // Reserved bits stay zero whatever was last written to them
  reg [31:0] ctl_word;
  always @* begin
    ctl_word = 32'h00000000; // RL15
    if (!is_ns) begin
      // Secure-only fields read as zero for non-secure accesses
      ctl_word[`DFC_SER_BIT] = ser_en; // RL11
      ctl_word[`DFC_LIM_HI:`DFC_LIM_LO] = lim_field; // RL11
      ctl_word[`DFC_ACC_HI:`DFC_ACC_LO] = acc_field; // RL11
    end
    ctl_word[`DFC_SCRUB_BIT] = scrub_on; // RL12
  end

  // APB answer: registered ready one cycle into the access phase
  // Read data and the error flag are loaded in the first access cycle,
  // while address and direction are steady, and stand with pready in
  // the second; every transfer therefore has exactly one wait state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= bus_access && !pready;
      if (bus_access && !pready) begin
        // Unmapped addresses answer with error and zero data
        pslverr <= !hit_any;
        if (pwrite) begin
          prdata <= 32'h00000000;
        end else if (hit_info) begin
          prdata <= dfc_width_word(DIRECT_INJECTION != 0, VPE_WIDTH);
        end else if (hit_ctl) begin
          prdata <= ctl_word;
        end else begin
          prdata <= 32'h00000000;
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Secure-only control fields; writes to the capability word drop
  // Non-secure writes reach only the scrub bit; the capability word
  // has no storage, so a write to it has nothing to land in.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_en <= `DFC_SER_RST; // RL6
      lim_field <= `DFC_LIM_RST;
      acc_field <= `DFC_ACC_RST; // RL10
    end else if (sec_write) begin // RL11
      ser_en <= pwdata[`DFC_SER_BIT];
      lim_field <= pwdata[`DFC_LIM_HI:`DFC_LIM_LO];
      acc_field <= pwdata[`DFC_ACC_HI:`DFC_ACC_LO];
    end
  end

  // Scrub bit: start or abort by software, cleared on completion
  // A start while a scrub runs is ignored; writing zero aborts it. The
  // walker lags the bit by one cycle, so the bit is the software view.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scrub_on <= 1'b0;
      walk_start <= 1'b0;
      walk_abort <= 1'b0;
    end else begin
      walk_start <= 1'b0;
      walk_abort <= 1'b0;
      if (ctl_write && wr_scrub && (!scrub_on || walk_done)) begin
        // Start wins over a completion in the same cycle, so a start
        // written just as a scrub ends is not lost
        scrub_on <= 1'b1; // RL12
        walk_start <= 1'b1;
      end else if (ctl_write && !wr_scrub && scrub_on) begin
        // Abort a running scrub
        scrub_on <= 1'b0; // RL12
        walk_abort <= 1'b1;
      end else if (walk_done) begin
        scrub_on <= 1'b0; // RL14
      end
    end
  end

  // Scrub sequencer over all local RAMs
  dfc_scrub_walker #(
    .NUM_RAMS(NUM_RAMS),
    .RAM_SEL_W(RAM_SEL_W),
    .ADDR_W(RAM_ADDR_W),
    .LAST_ADDR(RAM_LAST_ADDR)
  ) u_walker (
    .pclk(pclk),
    .presetn(presetn),
    .start(walk_start),
    .abort(walk_abort),
    .scrub_ack(scrub_ack),
    .scrub_req(walk_req),
    .scrub_ram(walk_ram),
    .scrub_addr(walk_addr),
    .done(walk_done)
  );

  // Scrub port passes straight through, unregistered; ack is qualified by the walker
  // The walker's own flops drive these pins; a second stage here would
  // put the request a cycle behind the acknowledge it is paired with.
  always @* begin
    scrub_req = walk_req;
    scrub_ram = walk_ram;
    scrub_addr = walk_addr;
  end

  // Settings handed to the rest of the local distributor only
  // The limit is decoded once here, so consumers never see a raw zero
  // or an out-of-range cap; both settings follow a write by one cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_lpi_limit <= TOKEN_MAX;
      err_spi_access <= `DFC_ACC_RST;
    end else begin
      // No path carries these settings to other chips
      cc_lpi_limit <= dfc_limit(lim_field, TOKEN_MAX); // RL5 RL8 RL9
      err_spi_access <= acc_field; // RL10
    end
  end

  // Remote shared-irq writes: hold the response only when
  // serializing an edge interrupt toward a remote chip
  // Level-type requests are never held back by the serialize control.
  // One request is in flight at a time: ready stays low from the take
  // until the forward is acknowledged and the machine is idle again.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_state <= ST_IDLE;
      spi_req_ready <= 1'b0;
      spi_resp_valid <= 1'b0;
      spi_fwd_valid <= 1'b0;
    end else begin
      spi_resp_valid <= 1'b0;
      case (fwd_state)
        ST_IDLE: begin
          spi_req_ready <= 1'b1;
          if (spi_req_valid && spi_req_ready) begin
            spi_req_ready <= 1'b0;
            if (!spi_req_remote) begin
              // Local target: answer at once
              spi_resp_valid <= 1'b1;
            end else if (ser_en && spi_req_edge) begin
              // Hold response until the remote chip has it
              spi_fwd_valid <= 1'b1; // RL6
              fwd_state <= ST_HOLD;
            end else begin
              // Store locally, answer now, forward later
              spi_resp_valid <= 1'b1; // RL7
              spi_fwd_valid <= 1'b1; // RL7
              fwd_state <= ST_POST;
            end
          end
        end
        // Waiting for the remote chip before the response goes out
        ST_HOLD: begin
          spi_req_ready <= 1'b0;
          if (spi_fwd_ack) begin
            spi_fwd_valid <= 1'b0;
            spi_resp_valid <= 1'b1; // RL6
            fwd_state <= ST_IDLE;
          end
        end
        // Response already given; only the forward is outstanding
        ST_POST: begin
          spi_req_ready <= 1'b0;
          if (spi_fwd_ack) begin
            spi_fwd_valid <= 1'b0;
            fwd_state <= ST_IDLE;
          end
        end
        default: begin
          spi_req_ready <= 1'b0;
          spi_fwd_valid <= 1'b0;
          fwd_state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> bench/dfc_props.sv
// Concurrent checks on the function-control bank ports.
// Assumes the dfc_top port list and the register map in dfc_defs.vh.
`include "dfc_defs.vh"
module dfc_props #(
  parameter DIRECT_INJECTION = 1,
  parameter [4:0] VPE_WIDTH = 5'h0F,
  parameter TOKEN_W = 4,
  parameter [TOKEN_W-1:0] TOKEN_MAX = 4'h8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`DFC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [2:0] pprot,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire spi_fwd_valid,
  input wire spi_fwd_ack,
  input wire [TOKEN_W-1:0] cc_lpi_limit,
  input wire [1:0] err_spi_access
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Commit edge of a function-control write
  wire fc_wr = pready && pwrite && paddr == `DFC_OFS_FUNC_CTL;
  wire sec = !pprot[`DFC_PROT_NS];
  wire [TOKEN_W-1:0] lim_f = pwdata[`DFC_LIM_HI:`DFC_LIM_LO];
  // Expected capability word
  wire [31:0] cap = DIRECT_INJECTION ?
    {24'h0, VPE_WIDTH != `DFC_WIDTH_16, 2'h0, VPE_WIDTH} : 32'h0;
  reg [TOKEN_W-1:0] exp_lim;
  reg [1:0] exp_acc;
  // Effective settings expected after each secure write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_lim <= TOKEN_MAX;
      exp_acc <= 2'h0;
    end else if (fc_wr && sec) begin
      exp_lim <= (lim_f == 0 || lim_f > TOKEN_MAX) ? TOKEN_MAX : lim_f;
      exp_acc <= pwdata[`DFC_ACC_HI:`DFC_ACC_LO];
    end
  end
  property p_rdy; psel && $rose(penable) |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("late pready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long pready");
  property p_err; pready |-> pslverr == !(paddr == `DFC_OFS_WIDTH_INFO
    || paddr == `DFC_OFS_FUNC_CTL); endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_cap; pready && !pwrite && paddr == `DFC_OFS_WIDTH_INFO
    |-> prdata == cap; endproperty
  a_cap: assert property (p_cap) else $error("bad width");
  property p_lim; fc_wr && sec |-> ##2 cc_lpi_limit == exp_lim; endproperty
  a_lim: assert property (p_lim) else $error("bad limit");
  property p_rng; cc_lpi_limit != 0 && cc_lpi_limit <= TOKEN_MAX;
  endproperty
  a_rng: assert property (p_rng) else $error("limit range");
  property p_acc; fc_wr && sec |-> ##2 err_spi_access == exp_acc;
  endproperty
  a_acc: assert property (p_acc) else $error("bad access");
  property p_ns; fc_wr && !sec
    |=> $stable({cc_lpi_limit, err_spi_access})[*3]; endproperty
  a_ns: assert property (p_ns) else $error("ns changed");
  property p_fwd; spi_fwd_valid && !spi_fwd_ack |=> spi_fwd_valid;
  endproperty
  a_fwd: assert property (p_fwd) else $error("fwd dropped");
  property p_drop; spi_fwd_valid && spi_fwd_ack |=> !spi_fwd_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("fwd stuck");
endmodule

bind dfc_top dfc_props #(.DIRECT_INJECTION(DIRECT_INJECTION),
  .VPE_WIDTH(VPE_WIDTH), .TOKEN_W(TOKEN_W), .TOKEN_MAX(TOKEN_MAX))
  u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pprot, .prdata, .pready, .pslverr, .spi_fwd_valid, .spi_fwd_ack,
  .cc_lpi_limit, .err_spi_access);

// >>> bench/tb.sv
// Directed bench for the function-control bank over APB.
// Assumes dfc_top with a short scrub; acks are made here.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam NR = 2;
  localparam LA = 3;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [2:0] pprot = 0;
  logic pready, pslverr, e, acked, scrub_req;
  logic spi_req_valid = 0, spi_req_edge = 0, spi_req_remote = 0;
  logic spi_req_ready, spi_resp_valid, spi_fwd_valid;
  logic spi_fwd_ack = 0, scrub_ack = 0;
  logic [3:0] cc_lpi_limit, fd = 0;
  logic [1:0] err_spi_access;
  logic [3:0] lims [5] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'h5};
  logic [3:0] xl;
  int error_cnt = 0, comparisons = 0, acks = 0;
  dfc_top #(.VPE_WIDTH(5'h0B), .NUM_RAMS(NR), .RAM_LAST_ADDR(10'h003))
    dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pprot, .prdata, .pready, .pslverr, .spi_req_valid, .spi_req_edge,
    .spi_req_remote, .spi_req_ready, .spi_resp_valid, .spi_fwd_valid,
    .spi_fwd_ack, .cc_lpi_limit, .err_spi_access, .scrub_req,
    .scrub_ram(), .scrub_addr(), .scrub_ack);
  initial forever #2.5 pclk = ~pclk;
  // Far-side responders: scrub ack every other cycle, slow forward ack
  always @(posedge pclk) begin
    scrub_ack <= scrub_req && !scrub_ack;
    fd <= {fd[2:0], spi_fwd_valid && !spi_fwd_ack};
    spi_fwd_ack <= fd[3] && spi_fwd_valid && !spi_fwd_ack;
    if (scrub_req && scrub_ack) acks++;
  end
  task wrap_up;
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("Error t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic ns);
    @(posedge pclk) psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge pclk) penable <= 1;
    // Wait for the answer; only the watchdog ends a hung transfer
    do @(posedge pclk); while (pready !== 1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic ns, input logic [31:0] x);
    apb(0, a, 0, ns);
    chk(x, r);
    chk(a != 12'h00C && a != 12'h020, e);
  endtask
  // Remote shared-irq write with serialize and edge settings
  task spi(input logic s, input logic ed);
    int n;
    apb(1, 12'h020, {5'h0, s, 26'h0}, 0);
    @(posedge pclk) spi_req_valid <= 1;
    spi_req_edge <= ed;
    spi_req_remote <= 1;
    n = 0;
    do @(posedge pclk) n++; while (spi_req_ready !== 1 && n < 50);
    spi_req_valid <= 0;
    acked = 0;
    n = 0;
    do begin
      @(posedge pclk) n++;
      if (spi_fwd_ack === 1) acked = 1;
    end while (spi_resp_valid !== 1 && n < 50);
    chk({s & ed, !(s & ed)}, {acked, n == 1});
  endtask
  initial begin
    #50us;
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rd(12'h00C, 0, 32'h8B);
    rd(12'h020, 0, 32'h0);
    chk(2'h0, err_spi_access);
    apb(1, 12'h00C, 32'hFFFFFFFF, 0);
    rd(12'h00C, 0, 32'h8B);
    rd(12'h010, 0, 32'h0);
    apb(1, 12'h020, 32'hFFFFFFFE, 0);
    rd(12'h020, 0, 32'h04F30000);
    chk(4'h8, cc_lpi_limit);
    chk(2'h3, err_spi_access);
    apb(1, 12'h020, 32'h0, 1);
    rd(12'h020, 0, 32'h04F30000);
    rd(12'h020, 1, 32'h0);
    foreach (lims[i]) begin
      apb(1, 12'h020, {8'h0, lims[i], 20'h0}, 0);
      rd(12'h020, 0, {8'h0, lims[i], 20'h0});
      xl = (lims[i] == 4'h0 || lims[i] > 4'h8) ? 4'h8 : lims[i];
      chk(xl, cc_lpi_limit);
    end
    spi(1, 1);
    spi(0, 1);
    spi(1, 0);
    acks = 0;
    apb(1, 12'h020, 32'h1, 1);
    rd(12'h020, 1, 32'h1);
    repeat (100) if (r[0] !== 0) begin
      apb(0, 12'h020, 0, 1);
      chk(0, e);
    end
    chk(0, r);
    chk(NR * (LA + 1), acks);
    apb(1, 12'h020, 32'h1, 0);
    apb(1, 12'h020, 32'h0, 0);
    repeat (2) @(posedge pclk);
    chk(0, scrub_req);
    rd(12'h020, 0, 32'h0);
    wrap_up;
  end
endmodule
